// ---- include/ltu_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the timer
`ifndef LTU_CFG_SVH
`define LTU_CFG_SVH

// Printed register indices; byte address is four times the index
`define LTU_IDX_RELOAD_CSR     8'h0C
`define LTU_IDX_RELOAD_VALUE   8'h0D
`define LTU_IDX_RELOAD_COUNT   8'h0E
`define LTU_IDX_BASE_CSR       8'h0F
`define LTU_IDX_CAPTURE        8'h10

// Field positions in the base tick / capture control-status register
`define LTU_CSR1_CAP_IRQ_EN    7
`define LTU_CSR1_CAP_FLAG      6
`define LTU_CSR1_PERIOD_DBL    5
`define LTU_CSR1_BASE_IRQ_EN   4
`define LTU_CSR1_BASE_FLAG     3

// Field positions in the reload tick control-status register
`define LTU_CSR2_RELOAD_IRQ_EN 1
`define LTU_CSR2_RELOAD_FLAG   0

// Reset values
`define LTU_RESET_BYTE         8'h00

// Timing: oscillator divide, base counter wrap point and reload counter top
`define LTU_PRESCALE           32
`define LTU_BASE_WRAP          8'hF9
`define LTU_RELOAD_TOP         8'hFF

`endif

// ---- include/ltu_pkg.sv ----
// Types shared by the timer block
package ltu_pkg;

    // Interrupt requests, one per event vector
    typedef struct packed {
        logic base_tick;
        logic reload_tick;
        logic capture;
    } ltu_irq_type;

    // Chip state inputs: halt and global interrupt mask
    typedef struct packed {
        logic halt;
        logic global_irq_mask;
    } ltu_sys_type;

    // Capture edge detector states
    typedef enum logic [1:0] {
        LTU_CAP_ARMED = 2'b01,
        LTU_CAP_HELD  = 2'b10
    } ltu_cap_state_type;

endpackage

// ---- logic/ltu_timer.sv ----
// Lite timebase and capture timer with APB register access
`timescale 1ns/1ns
`default_nettype none
`include "ltu_cfg.svh"

// Functional notes
// - Base counter from zero, every 32 clocks, hidden
// - Base overflow on F9h to 00h wrap
// - Period double select gives 16000 clocks
// - Base overflow sets flag, gated interrupt request
// - Reading first status clears base flag
// - Capture pin edge latches base counter, flags
// - Reading capture register clears capture flag
// - Capture held while capture flag set
// - Capture register read-only, resets to zero
// - Reload counter starts at reload value
// - Reload counter overflow past FFh reloads
// - New reload value applied at next overflow
// - Reload counter readable, writes ignored
// - Reload overflow sets flag, gated interrupt
// - Reading second status clears reload flag
// - Counters stop in halt only
// - Separate interrupt lines, gated by global mask
module ltu_timer #(
    parameter int PRESCALE = `LTU_PRESCALE
) (
    // Clock and reset
    input  wire logic                 MCLK,
    input  wire logic                 RST_B,
    // APB slave
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [11:0]          PADDR,
    input  wire logic [31:0]          PWDATA,
    output logic      [31:0]          PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    // Chip state and capture pin
    input  wire ltu_pkg::ltu_sys_type SYS,
    input  wire logic                 CAPTURE_PIN,
    // Interrupt requests
    output ltu_pkg::ltu_irq_type      IRQ
);
    import ltu_pkg::*;

    localparam int PW = $clog2(PRESCALE);

    logic [PW-1:0]     prescale_cnt;
    logic              tick;
    logic [7:0]        base_cnt;
    logic              base_half;
    logic              base_event;
    logic [7:0]        reload_cnt;
    logic [7:0]        reload_value;
    logic              reload_event;
    logic              period_double_sel;
    logic              base_tick_irq_en;
    logic              base_tick_flag;
    logic              capture_irq_en;
    logic              capture_flag;
    logic              reload_tick_irq_en;
    logic              reload_tick_flag;
    logic [7:0]        capture_value;
    logic              cap_sync1;
    logic              cap_sync2;
    logic              cap_prev;
    logic              cap_edge;
    logic [2:0]        cap_seen;
    ltu_cap_state_type cap_state;
    logic              access;
    logic              wr;
    logic              rd;
    logic [9:0]        idx;
    logic              mapped;
    logic [7:0]        next_rdata;

    // Single wait-free access phase
    assign PREADY  = 1'b1;
    assign access  = PSEL && PENABLE;
    // Misaligned or unmapped accesses neither write nor clear flags
    assign wr      = access && PWRITE && mapped;
    assign rd      = access && !PWRITE && mapped;
    assign idx     = PADDR[11:2];
    assign mapped  = (PADDR[1:0] == 2'b00) && (idx >= 10'(`LTU_IDX_RELOAD_CSR))
                     && (idx <= 10'(`LTU_IDX_CAPTURE));
    assign PSLVERR = access && !mapped;

    // Prescaler; halt freezes the timebase only
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            prescale_cnt <= '0;
        end else if (!SYS.halt) begin
            if (prescale_cnt == PW'(PRESCALE - 1)) begin
                prescale_cnt <= '0;
            end else begin
                prescale_cnt <= prescale_cnt + 1'b1;
            end
        end
    end
    assign tick = !SYS.halt && (prescale_cnt == PW'(PRESCALE - 1));

    // Base counter wraps at F9h; the event fires every wrap or every second wrap
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            base_cnt  <= 8'h00;
            base_half <= 1'b0;
        end else if (tick) begin
            if (base_cnt == `LTU_BASE_WRAP) begin
                base_cnt  <= 8'h00;
                base_half <= !base_half;
            end else begin
                base_cnt <= base_cnt + 8'h01;
            end
        end
    end
    assign base_event = tick && (base_cnt == `LTU_BASE_WRAP)
                        && (!period_double_sel || base_half);

    // Reload counter; reset value equals reload reset value
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            reload_cnt <= `LTU_RESET_BYTE;
        end else if (tick) begin
            if (reload_cnt == `LTU_RELOAD_TOP) begin
                reload_cnt <= reload_value;
            end else begin
                reload_cnt <= reload_cnt + 8'h01;
            end
        end
    end
    assign reload_event = tick && (reload_cnt == `LTU_RELOAD_TOP);

    // Software controls; flags are never written
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            reload_value       <= `LTU_RESET_BYTE;
            period_double_sel  <= 1'b0;
            base_tick_irq_en   <= 1'b0;
            capture_irq_en     <= 1'b0;
            reload_tick_irq_en <= 1'b0;
        end else if (wr) begin
            case (idx)
                10'(`LTU_IDX_RELOAD_VALUE): begin
                    reload_value <= PWDATA[7:0];
                end
                10'(`LTU_IDX_BASE_CSR): begin
                    capture_irq_en    <= PWDATA[`LTU_CSR1_CAP_IRQ_EN];
                    period_double_sel <= PWDATA[`LTU_CSR1_PERIOD_DBL];
                    base_tick_irq_en  <= PWDATA[`LTU_CSR1_BASE_IRQ_EN];
                end
                10'(`LTU_IDX_RELOAD_CSR): begin
                    reload_tick_irq_en <= PWDATA[`LTU_CSR2_RELOAD_IRQ_EN];
                end
                default: begin
                end
            endcase
        end
    end

    // Event flags: a set in the same cycle as the clearing read wins
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            base_tick_flag <= 1'b0;
        end else if (base_event) begin
            base_tick_flag <= 1'b1;
        end else if (rd && idx == 10'(`LTU_IDX_BASE_CSR)) begin
            base_tick_flag <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            reload_tick_flag <= 1'b0;
        end else if (reload_event) begin
            reload_tick_flag <= 1'b1;
        end else if (rd && idx == 10'(`LTU_IDX_RELOAD_CSR)) begin
            reload_tick_flag <= 1'b0;
        end
    end

    // Capture pin synchroniser; only the second stage feeds the detector
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            cap_sync1 <= 1'b0;
            cap_sync2 <= 1'b0;
            cap_prev  <= 1'b0;
            cap_seen  <= 3'h0;
        end else begin
            cap_sync1 <= CAPTURE_PIN;
            cap_sync2 <= cap_sync1;
            cap_prev  <= cap_sync2;
            cap_seen  <= {cap_seen[1:0], 1'b1};
        end
    end
    // No edge until both compared stages hold real pin samples; a pin idling
    // high would otherwise fake an edge just after reset
    assign cap_edge = cap_seen[2] && (cap_sync2 != cap_prev);

    // Flag reset is a known clear, which also satisfies the read-once advice
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            cap_state     <= LTU_CAP_ARMED;
            capture_value <= 8'h00;
        end else begin
            case (cap_state)
                LTU_CAP_ARMED: begin
                    if (cap_edge) begin
                        capture_value <= base_cnt;
                        cap_state     <= LTU_CAP_HELD;
                    end
                end
                LTU_CAP_HELD: begin
                    if (rd && idx == 10'(`LTU_IDX_CAPTURE)) begin
                        cap_state <= LTU_CAP_ARMED;
                    end
                end
                default: begin
                    cap_state <= LTU_CAP_ARMED;
                end
            endcase
        end
    end
    assign capture_flag = (cap_state == LTU_CAP_HELD);

    // Read mux; unused control bits read as zero
    always_comb begin
        next_rdata = 8'h00;
        case (idx)
            10'(`LTU_IDX_RELOAD_CSR): begin
                next_rdata[`LTU_CSR2_RELOAD_IRQ_EN] = reload_tick_irq_en;
                next_rdata[`LTU_CSR2_RELOAD_FLAG]   = reload_tick_flag;
            end
            10'(`LTU_IDX_RELOAD_VALUE): next_rdata = reload_value;
            10'(`LTU_IDX_RELOAD_COUNT): next_rdata = reload_cnt;
            10'(`LTU_IDX_BASE_CSR): begin
                next_rdata[`LTU_CSR1_CAP_IRQ_EN]  = capture_irq_en;
                next_rdata[`LTU_CSR1_CAP_FLAG]    = capture_flag;
                next_rdata[`LTU_CSR1_PERIOD_DBL]  = period_double_sel;
                next_rdata[`LTU_CSR1_BASE_IRQ_EN] = base_tick_irq_en;
                next_rdata[`LTU_CSR1_BASE_FLAG]   = base_tick_flag;
            end
            10'(`LTU_IDX_CAPTURE): next_rdata = capture_value;
            default: next_rdata = 8'h00;
        endcase
        if (!mapped) begin
            next_rdata = 8'h00;
        end
    end
    assign PRDATA = {24'h000000, next_rdata};

    // One request line per event, gated by enable and global mask
    assign IRQ.base_tick   = base_tick_flag && base_tick_irq_en
                             && !SYS.global_irq_mask;
    assign IRQ.reload_tick = reload_tick_flag && reload_tick_irq_en
                             && !SYS.global_irq_mask;
    assign IRQ.capture     = capture_flag && capture_irq_en
                             && !SYS.global_irq_mask;

    // Assertions
    base_wrap_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (tick && base_cnt == 8'hF9) |=> (base_cnt == 8'h00))
        else $error("base counter did not wrap at F9h");

    base_hidden_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        !tick |=> $stable(base_cnt))
        else $error("base counter moved without a tick");

    double_period_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (period_double_sel && base_event) |=> !base_half)
        else $error("double period event not followed by idle half");

    base_flag_set_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        base_event |=> base_tick_flag)
        else $error("base flag not set on overflow");

    base_flag_clr_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (rd && idx == 10'h00F && !base_event) |=> !base_tick_flag)
        else $error("base flag not cleared by status read");

    capture_take_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (cap_edge && !capture_flag) |=> (capture_flag && capture_value == $past(base_cnt)))
        else $error("capture did not latch base counter");

    capture_clr_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (rd && idx == 10'h010 && capture_flag) |=> !capture_flag)
        else $error("capture flag not cleared by read");

    capture_hold_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        capture_flag |=> $stable(capture_value))
        else $error("capture register changed while flag set");

    reload_load_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        reload_event |=> (reload_cnt == $past(reload_value)))
        else $error("reload counter not reloaded on overflow");

    reload_flag_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        reload_event |=> reload_tick_flag)
        else $error("reload flag not set on overflow");

    reload_flag_clr_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (rd && idx == 10'h00C && !reload_event) |=> !reload_tick_flag)
        else $error("reload flag not cleared by status read");

    halt_freeze_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        SYS.halt |=> ($stable(reload_cnt) && $stable(base_cnt)))
        else $error("counter advanced in halt");

    irq_mask_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        SYS.global_irq_mask |-> (IRQ == 3'b000))
        else $error("interrupt raised while globally masked");

endmodule
`default_nettype wire

// ---- verification/ltu_edge_src.sv ----
// Capture pin source: flips the pin one edge after a request
`timescale 1ns/1ns
`default_nettype none
module ltu_edge_src (
    // Clock and request
    input  wire logic MCLK,
    input  wire logic flip,
    // Driven pin, always actively driven
    output logic      pin
);
    logic level = 1'b0;

    // Pin idles low; one driver only
    always @(posedge MCLK) begin
        if (flip) begin
            level <= ~level;
        end
    end
    assign pin = level;
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the lite timer
`timescale 1ns/1ns
`default_nettype none
`include "ltu_cfg.svh"
module tb_top;
    import ltu_pkg::*;
    localparam int P = 8;
    localparam int CS2 = `LTU_IDX_RELOAD_CSR;
    localparam int ARV = `LTU_IDX_RELOAD_VALUE;
    localparam int CNT = `LTU_IDX_RELOAD_COUNT;
    localparam int CS1 = `LTU_IDX_BASE_CSR;
    localparam int CAP = `LTU_IDX_CAPTURE;
    int          reg_idx [4] = '{CS2, ARV, CS1, CAP};
    logic        MCLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, flip = 0, pin;
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA, rd, lf = 32'h651AFFB6;
    logic        PREADY, PSLVERR, err, of = 0;
    logic [5:0]  fl;
    ltu_sys_type SYS = '0;
    ltu_irq_type IRQ, irq_s;
    int          fail_count = 0, tests_run = 0, cyc = 0, tl, T, rc, rv, tr, k, n, b;

    ltu_timer #(.PRESCALE(P)) dut (.MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SYS(SYS),
        .CAPTURE_PIN(pin), .IRQ(IRQ));
    ltu_edge_src src (.MCLK(MCLK), .flip(flip), .pin(pin));

    always #5 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            summarize();
        end
    end

    function logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction

    task summarize();
        $display("compared %0d, mismatched %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Captured value may land either side of one tick
    task chk_in(input logic [31:0] got, input int a, input int c);
        tests_run++;
        if (got !== a && got !== c) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h or %h", $time, got, a, c);
        end
    endtask

    task apb(input logic w, input int idx, input logic [7:0] d);
        @(posedge MCLK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= 12'(idx * 4);
        PWDATA <= {24'h0, d};
        @(posedge MCLK);
        PENABLE <= 1;
        do @(posedge MCLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        irq_s = IRQ;
        tr = cyc;
        PSEL <= 0;
        PENABLE <= 0;
    endtask

    // Advance the model by the unhalted ticks since the last count read
    task adv(input int t, input int h);
        repeat ((t - tl - h) / P) begin
            T++;
            if (rc == 255) begin
                rc = rv;
                of = 1;
            end else begin
                rc++;
            end
        end
        tl = t;
    endtask

    task rdc(input int t, input int h);
        while (cyc < t - 3) @(posedge MCLK);
        apb(0, CNT, 0);
        adv(tr, h);
        chk(rd, rc);
    endtask

    initial begin
        repeat (20) @(posedge MCLK);
        RST_B <= 1;
        tl = cyc;
        apb(0, CNT, 0);
        chk_in(rd, (tr - tl) / P, (tr - tl) / P - 1);
        chk(err, 0);
        rc = rd;
        T = rd;
        tl = tr;
        rv = 0;
        foreach (reg_idx[i]) begin
            apb(0, reg_idx[i], 0);
            chk(rd, 0);
        end
        apb(0, 'h11, 0);
        chk(rd, 0);
        chk(err, 1);
        apb(1, CAP, 8'hA5);
        apb(0, CAP, 0);
        chk(rd, 0);
        apb(1, CS1, 8'h48);
        apb(0, CS1, 0);
        chk(rd, 0);
        apb(1, CS2, 8'h01);
        apb(0, CS2, 0);
        chk(rd, 0);
        apb(1, CS2, 8'h02);
        $display("reset and access test done");
        for (int i = 0; i < 16; i++) begin
            k = 3 + rnd() % 60;
            n = (i % 3 == 1) ? 4 * P : 0;
            SYS.global_irq_mask <= lf[3];
            if (n > 0) begin
                @(posedge MCLK);
                SYS.halt <= 1;
                repeat (n) @(posedge MCLK);
                SYS.halt <= 0;
            end
            rdc(tl + k * P + n, n);
            if (i % 4 == 2) begin
                apb(1, CNT, lf[7:0]);
            end
            if (rc != 255 && i % 2 == 0) begin
                rv = 32'h80 | (lf & 32'h7F);
                apb(1, ARV, 8'(rv));
            end else if (rc != 255) begin
                apb(0, CS2, 0);
                chk(rd, {30'h0, 1'b1, of});
                chk(irq_s.reload_tick, of & !SYS.global_irq_mask);
                of = 0;
            end
        end
        $display("reload counter test done");
        apb(1, CS1, 8'h10);
        apb(0, CS1, 0);
        for (int i = 0; i < 6; i++) begin
            if (i == 3) begin
                apb(1, CS1, 8'h30);
                apb(0, CS1, 0);
            end
            SYS.global_irq_mask <= rnd() > 32'h7FFFFFFF;
            repeat (250 * P - 3) @(posedge MCLK);
            apb(0, CS1, 0);
            fl[i] = rd[3];
            if (i < 3) begin
                chk(irq_s.base_tick, !SYS.global_irq_mask);
            end
        end
        chk(fl[2:0], 3'h7);
        chk({fl[3] ^ fl[4], fl[4] ^ fl[5]}, 2'h3);
        $display("base tick test done");
        apb(1, CS1, 8'h80);
        apb(0, CAP, 0);
        for (int i = 0; i < 3; i++) begin
            rdc(tl + P * ((cyc - tl) / P + 3), 0);
            flip <= 1;
            @(posedge MCLK);
            flip <= 0;
            b = T % 250;
            repeat (8) @(posedge MCLK);
            apb(0, CS1, 0);
            chk(rd & 32'hC0, 32'hC0);
            chk(irq_s.capture, !SYS.global_irq_mask);
            if (i == 0) begin
                flip <= 1;
                @(posedge MCLK);
                flip <= 0;
                repeat (16) @(posedge MCLK);
            end
            apb(0, CAP, 0);
            chk_in(rd, b, (b + 1) % 250);
            apb(0, CS1, 0);
            chk(rd[6], 0);
        end
        $display("capture test done");
        summarize();
    end
endmodule
`default_nettype wire
